/* File: bench/tb.sv */
/*
  Self-checking bench for the USB host sequencer with a behavioural USB module.
  Assumes a shortened millisecond of MSC cycles.
*/
`timescale 1ns/1ps
module tb;
  import usbh_pkg::*;
  localparam int unsigned MSC = 200;
  logic mclk = 0, reset_n = 0, sw_wr = 0, sw_rd = 0, line_se0 = 0;
  logic [7:0] sw_addr = 8'h00, dev_addr;
  logic [15:0] sw_wdata = 16'h0000, sw_rdata, dev_wdata, dev_rdata, d;
  logic dev_wr, dev_rd;
  logic [3:0] pid = 4'h2, ep;
  logic [6:0] tgt;
  logic [9:0] len;
  int mismatches = 0, checked = 0, cyc = 0, setup_at = 0, setup_gap = 0;
  logic [3:0] pids [4] = '{4'h2, PID_NAK, PID_STALL, PID_ERR};
  always #20 mclk = ~mclk;
  usbh_ctl #(.MS_CYCLES(MSC)) DUT (.mclk(mclk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .line_se0(line_se0));
  usbh_dev M (.mclk(mclk), .reset_n(reset_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .line_se0(line_se0), .pid(pid));
  function automatic logic [15:0] ep0_exp(input logic bulk, input logic ls, input logic nr);
    return (bulk ? 16'h001D : 16'h000D) | {8'h00, ls, nr, 6'h00};
  endfunction
  function automatic logic [15:0] st_exp(input logic [3:0] p, input logic e);
    return {8'h00, p, 1'b0, e, 2'b10};
  endfunction
  task chk(input string n, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task run(input logic [1:0] c);
    wr(REG_CMD, {14'h0000, c});
    for (int i = 0; i < 3000; i++) begin
      rd(REG_STATUS, d);
      if (d[1] === 1'b1) break;
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (dev_wr && dev_addr == DEV_TOK && dev_wdata == TOK_SETUP) begin
      setup_gap = cyc - setup_at;
      setup_at = cyc;
    end
    if (cyc == 80000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    d = $urandom(84);
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      tgt = 7'(1 + $urandom % 127);
      wr(REG_TARGET, {9'h000, tgt});
      wr(REG_CFG, (j == 1) ? 16'h0001 : 16'h0000);
      wr(REG_BUF, 16'h0200);
      run(CMD_CTRL_IN);
      chk("ep0", ep0_exp(0, j == 1, 0), M.r[DEV_EP0]);
      chk("addr", tgt, M.r[DEV_ADDR]);
      chk("tokens", 24'hD09001, M.tok_log);
      chk("bdstat", {BD_SETUP, BD_DATA_IN, BD_STATUS}, M.bd_log);
      chk("bdadr", 16'h0208, M.r[DEV_BD_ADR]);
      chk("status", st_exp(4'h2, 0), d);
    end
    chk("frame gap", 1, setup_gap >= MSC);
    rd(8'h3F, d);
    chk("unmapped", 16'h0000, d);
    $display("test control in done");
    for (int k = 0; k < 4; k++) begin
      pid <= pids[k];
      ep = 4'(1 + $urandom % 15);
      len = (k == 0) ? 10'h040 : 10'($urandom);
      wr(REG_CFG, 16'h0003);
      wr(REG_EP, {12'h000, ep});
      wr(REG_LEN, {6'h00, len});
      run(CMD_BULK_OUT);
      chk("ep0", ep0_exp(1, 1, 1), M.r[DEV_EP0]);
      chk("token", {PID_OUT, ep}, M.tok_log[7:0]);
      chk("bdstat", 16'h8000 | ((len > BULK_MAX) ? BULK_MAX : len), M.bd_log[15:0]);
      chk("status", st_exp(pid, k != 0), d);
    end
    $display("test bulk out done");
    @(posedge mclk) line_se0 <= 1'b1;
    run(CMD_BULK_OUT);
    chk("detach", 16'h000E, d & 16'h000F);
    $display("test detach done");
    run(CMD_SRP);
    @(posedge mclk) line_se0 <= 1'b0;
    chk("otgcon", 16'h0080, M.r[DEV_OTGCON]);
    chk("cfg2", 16'h0000, M.r[DEV_CFG2]);
    chk("otgir", 16'h0000, M.r[DEV_OTGIR]);
    chk("pulse", 1, M.dp_len >= int'(DPULSE_MS) * MSC && M.dp_len <= int'(DPULSE_MS) * MSC + 4);
    $display("test srp done");
    wrap_up;
  end
endmodule // tb

/* File: bench/usbh_dev.sv */
/*
  Behavioural USB module: register file, token engine with settable handshake, SRP flags.
  Assumes the register map and read timing of the host sequencer package.
*/
`timescale 1ns/1ps
module usbh_dev (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [15:0] dev_rdata,
  input wire logic line_se0,
  input wire logic [3:0] pid
);
  import usbh_pkg::*;
  logic [15:0] r [0:31];
  logic [23:0] tok_log;
  logic [47:0] bd_log;
  logic [7:0] busy;
  logic [15:0] dp_cnt, dp_len;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) r[i] <= 16'h0000;
      r[DEV_OTGIR] <= 16'h0004;
      {tok_log, bd_log, busy, dp_cnt, dp_len, dev_rdata} <= '0;
    end else begin
      dev_rdata <= dev_rd ? r[dev_addr[4:0]] : ~dev_rdata;
      if (dev_wr && (dev_addr == DEV_IR || dev_addr == DEV_OTGIR)) begin
        r[dev_addr[4:0]] <= r[dev_addr[4:0]] & ~dev_wdata;
      end else if (dev_wr) begin
        r[dev_addr[4:0]] <= dev_wdata;
      end
      if (busy != 8'h00) busy <= busy - 8'h01;
      if (busy == 8'h01) begin
        if (line_se0) r[DEV_IR][IR_DETACH_BIT] <= 1'b1;
        else begin
          r[DEV_IR][IR_TRN_BIT] <= 1'b1;
          r[DEV_BD_STAT] <= {10'h000, pid, 2'b00};
        end
      end
      if (dev_wr && dev_addr == DEV_TOK) begin
        busy <= 8'h04 + 8'($urandom % 8);
        tok_log <= {tok_log[15:0], dev_wdata[7:0]};
        bd_log <= {bd_log[31:0], r[DEV_BD_STAT]};
      end
      if (r[DEV_OTGCON][OTGCON_DPPU_BIT] && !r[DEV_CFG2][CFG2_VBUS_PULSE_ENABLE_BIT]) dp_cnt <= dp_cnt + 16'h0001;
      if (dev_wr && dev_addr == DEV_CFG2 && dev_wdata[CFG2_VBUS_PULSE_ENABLE_BIT]) begin
        dp_len <= dp_cnt;
        r[DEV_OTGIR][OTGIR_SESVD_BIT] <= 1'b1;
      end
    end
  end
endmodule // usbh_dev

/* File: hw/usbh_ctl.sv */
/*
  Host sequencer that drives a dual-role USB module through its register port: control
  read transfers, bulk OUT packets and the B-device session request.
  Assumes the module answers a read one cycle after the read strobe and never stalls.
*/
`timescale 1ns/1ps
module usbh_ctl #(
  parameter int unsigned MS_CYCLES = usbh_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  output logic [7:0] dev_addr,
  output logic [15:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [15:0] dev_rdata,
  input wire logic line_se0
);
  import usbh_pkg::*;
  localparam int unsigned FW = $clog2(MS_CYCLES + 1);
  localparam logic [FW-1:0] FRAME_FULL = FW'(MS_CYCLES);
  localparam logic [15:0] TRN_MASK = 16'h0001 << IR_TRN_BIT;
  localparam logic [15:0] SESEND_MASK = 16'h0001 << OTGIR_SESEND_BIT;
  localparam logic [15:0] SESVD_MASK = 16'h0001 << OTGIR_SESVD_BIT;
  localparam logic [15:0] DPPU_VAL = 16'h0001 << OTGCON_DPPU_BIT;
  localparam logic [15:0] VBUS_DISCHARGE_ENABLE_VAL = 16'h0001 << OTGCON_VBUS_DISCHARGE_ENABLE_BIT;
  localparam logic [15:0] VBUS_PULSE_ENABLE_VAL = 16'h0001 << CFG2_VBUS_PULSE_ENABLE_BIT;

  usbh_tmr_if tif ();
  usbh_tmr #(.MS_CYCLES(MS_CYCLES)) u_tmr (.mclk(mclk), .reset_n(reset_n), .tif(tif));

  logic se0_m;
  logic se0_s;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      se0_m <= 1'b0;
      se0_s <= 1'b0;
    end else begin
      se0_m <= line_se0;
      se0_s <= se0_m;
    end
  end

  // Software-facing configuration and command registers.
  logic [6:0] target;
  logic [6:0] next_target;
  logic cfg_ls;
  logic next_cfg_ls;
  logic cfg_noretry;
  logic next_cfg_noretry;
  logic [15:0] buf_ptr;
  logic [15:0] next_buf_ptr;
  logic [9:0] len;
  logic [9:0] next_len;
  logic [3:0] ep;
  logic [3:0] next_ep;
  logic [1:0] op;
  logic [1:0] next_op;
  logic [15:0] next_sw_rdata;
  logic cmd_go;
  logic busy;
  logic done;
  logic err;
  logic det;
  logic [3:0] pid;
  logic [9:0] count;

  always_comb begin
    next_target = target;
    next_cfg_ls = cfg_ls;
    next_cfg_noretry = cfg_noretry;
    next_buf_ptr = buf_ptr;
    next_len = len;
    next_ep = ep;
    next_op = op;
    cmd_go = 1'b0;
    if (sw_wr) begin
      case (sw_addr)
        REG_CMD: begin
          if (!busy && sw_wdata[1:0] != 2'h0) begin
            next_op = sw_wdata[1:0];
            cmd_go = 1'b1;
          end
        end
        REG_TARGET: next_target = sw_wdata[6:0];
        REG_CFG: begin
          if (!busy) begin
            next_cfg_ls = sw_wdata[0];
            next_cfg_noretry = sw_wdata[1];
          end
        end
        REG_BUF: next_buf_ptr = sw_wdata;
        REG_LEN: next_len = sw_wdata[9:0];
        REG_EP: next_ep = sw_wdata[3:0];
        default: ;
      endcase
    end
    case (sw_addr)
      REG_CMD: next_sw_rdata = {14'h0000, op};
      REG_TARGET: next_sw_rdata = {9'h000, target};
      REG_CFG: next_sw_rdata = {14'h0000, cfg_noretry, cfg_ls};
      REG_BUF: next_sw_rdata = buf_ptr;
      REG_LEN: next_sw_rdata = {6'h00, len};
      REG_EP: next_sw_rdata = {12'h000, ep};
      REG_STATUS: next_sw_rdata = {8'h00, pid, det, err, done, busy};
      REG_COUNT: next_sw_rdata = {6'h00, count};
      default: next_sw_rdata = 16'h0000;
    endcase
    if (!sw_rd) begin
      next_sw_rdata = 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      target <= 7'h00;
      cfg_ls <= 1'b0;
      cfg_noretry <= 1'b0;
      buf_ptr <= 16'h0000;
      len <= 10'h000;
      ep <= 4'h0;
      op <= 2'h0;
      sw_rdata <= 16'h0000;
    end else begin
      target <= next_target;
      cfg_ls <= next_cfg_ls;
      cfg_noretry <= next_cfg_noretry;
      buf_ptr <= next_buf_ptr;
      len <= next_len;
      ep <= next_ep;
      op <= next_op;
      sw_rdata <= next_sw_rdata;
    end
  end

  // Step table: each command is a fixed list of register accesses and waits.
  usbh_state_e state;
  usbh_state_e next_state;
  logic [4:0] idx;
  logic [4:0] next_idx;
  usbh_step_s step;
  logic [15:0] ep0_val;
  logic [9:0] bulk_cnt;

  assign ep0_val = {8'h00, cfg_ls, cfg_noretry, 6'h00};
  assign bulk_cnt = (len > BULK_MAX) ? BULK_MAX : len;
  assign busy = (state != S_IDLE);

  function automatic usbh_step_s mk(usbh_kind_e k, logic [7:0] a, logic [15:0] d);
    mk = '{kind: k, addr: a, data: d, ms: 4'h0};
  endfunction

  always_comb begin
    step = mk(K_DONE, 8'h00, 16'h0000);
    case (op)
      CMD_CTRL_IN: begin
        case (idx)
          5'd0: step = mk(K_WAITF, 8'h00, 16'h0000);
          5'd1: step = mk(K_WR, DEV_EP0, EP0_CTRL_VAL | ep0_val);
          5'd2: step = mk(K_WR, DEV_ADDR, {9'h000, target});
          5'd3: step = mk(K_WR, DEV_BD_ADR, buf_ptr);
          5'd4: step = mk(K_WR, DEV_BD_STAT, BD_SETUP);
          5'd5: step = mk(K_WR, DEV_TOK, TOK_SETUP);
          5'd6: step = mk(K_POLL, DEV_IR, TRN_MASK);
          5'd7: step = mk(K_RD, DEV_BD_STAT, 16'h0000);
          5'd8: step = mk(K_WR, DEV_IR, TRN_MASK);
          5'd9: step = mk(K_WR, DEV_BD_ADR, 16'(buf_ptr + SETUP_LEN));
          5'd10: step = mk(K_WR, DEV_BD_STAT, BD_DATA_IN);
          5'd11: step = mk(K_WR, DEV_TOK, TOK_IN);
          5'd12: step = mk(K_POLL, DEV_IR, TRN_MASK);
          5'd13: step = mk(K_RD, DEV_BD_STAT, 16'h0001);
          5'd14: step = mk(K_WR, DEV_IR, TRN_MASK);
          5'd15: step = mk(K_WR, DEV_BD_STAT, BD_STATUS);
          5'd16: step = mk(K_WR, DEV_TOK, TOK_OUT_EP0);
          5'd17: step = mk(K_POLL, DEV_IR, TRN_MASK);
          5'd18: step = mk(K_RD, DEV_BD_STAT, 16'h0000);
          5'd19: step = mk(K_WR, DEV_IR, TRN_MASK);
          default: step = mk(K_DONE, 8'h00, 16'h0000);
        endcase
      end
      CMD_BULK_OUT: begin
        case (idx)
          5'd0: step = mk(K_WR, DEV_EP0, EP0_BULK_VAL | ep0_val);
          5'd1: step = mk(K_WR, DEV_ADDR, {9'h000, target});
          5'd2: step = mk(K_WR, DEV_BD_ADR, buf_ptr);
          5'd3: step = mk(K_WR, DEV_BD_STAT, BD_STATUS | {6'h00, bulk_cnt});
          5'd4: step = mk(K_WR, DEV_TOK, {8'h00, PID_OUT, ep});
          5'd5: step = mk(K_POLL, DEV_IR, TRN_MASK);
          5'd6: step = mk(K_RD, DEV_BD_STAT, 16'h0001);
          5'd7: step = mk(K_WR, DEV_IR, TRN_MASK);
          default: step = mk(K_DONE, 8'h00, 16'h0000);
        endcase
      end
      CMD_SRP: begin
        case (idx)
          5'd0: step = mk(K_POLL, DEV_OTGIR, SESEND_MASK);
          5'd1: step = mk(K_WR, DEV_OTGIR, SESEND_MASK);
          5'd2: step = mk(K_WR, DEV_OTGCON, VBUS_DISCHARGE_ENABLE_VAL);
          5'd3: step = '{kind: K_WAITSE0, addr: 8'h00, data: 16'h0000, ms: SE0_IDLE_MS};
          5'd4: step = mk(K_WR, DEV_OTGCON, DPPU_VAL);
          5'd5: step = '{kind: K_WAITMS, addr: 8'h00, data: 16'h0000, ms: DPULSE_MS};
          5'd6: step = mk(K_WR, DEV_OTGCON, 16'h0000);
          5'd7: step = mk(K_WR, DEV_CFG2, VBUS_PULSE_ENABLE_VAL);
          5'd8: step = mk(K_POLL, DEV_OTGIR, SESVD_MASK);
          5'd9: step = mk(K_WR, DEV_CFG2, 16'h0000);
          5'd10: step = mk(K_WR, DEV_OTGIR, SESVD_MASK);
          5'd11: step = mk(K_WR, DEV_OTGCON, DPPU_VAL);
          default: step = mk(K_DONE, 8'h00, 16'h0000);
        endcase
      end
      default: step = mk(K_DONE, 8'h00, 16'h0000);
    endcase
  end

  // Engine: walks the step table and drives the module's register port.
  logic [FW-1:0] frame_cnt;
  logic [FW-1:0] next_frame_cnt;
  logic next_dev_wr;
  logic next_dev_rd;
  logic [7:0] next_dev_addr;
  logic [15:0] next_dev_wdata;
  logic next_done;
  logic next_err;
  logic next_det;
  logic [3:0] next_pid;
  logic [9:0] next_count;
  logic [3:0] rd_pid;

  assign rd_pid = dev_rdata[BD_PID_LSB +: 4];
  assign tif.ms = step.ms;

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_dev_wr = 1'b0;
    next_dev_rd = 1'b0;
    next_dev_addr = dev_addr;
    next_dev_wdata = dev_wdata;
    next_done = done;
    next_err = err;
    next_det = det;
    next_pid = pid;
    next_count = count;
    next_frame_cnt = (frame_cnt == FRAME_FULL) ? frame_cnt : FW'(frame_cnt + 1'b1);
    tif.start = 1'b0;
    case (state)
      S_IDLE: begin
        if (cmd_go) begin
          next_state = S_EXEC;
          next_idx = 5'd0;
          next_done = 1'b0;
          next_err = 1'b0;
          next_det = 1'b0;
        end
      end
      S_EXEC: begin
        case (step.kind)
          K_WR: begin
            next_dev_wr = 1'b1;
            next_dev_addr = step.addr;
            next_dev_wdata = step.data;
            next_idx = 5'(idx + 1'b1);
            if (err && step.addr == DEV_IR) begin
              next_state = S_IDLE;
              next_done = 1'b1;
            end
          end
          K_POLL, K_RD: begin
            next_dev_rd = 1'b1;
            next_dev_addr = step.addr;
            next_state = S_RDS;
          end
          K_WAITF: begin
            if (frame_cnt == FRAME_FULL) begin
              next_frame_cnt = '0;
              next_idx = 5'(idx + 1'b1);
            end
          end
          K_WAITSE0, K_WAITMS: begin
            tif.start = 1'b1;
            next_state = S_TMR;
          end
          default: begin
            next_state = S_IDLE;
            next_done = 1'b1;
          end
        endcase
      end
      S_RDS: next_state = S_RDD;
      S_RDD: begin
        next_state = S_EXEC;
        if (step.kind == K_POLL) begin
          if (step.addr == DEV_IR && dev_rdata[IR_DETACH_BIT]) begin
            next_det = 1'b1;
            next_err = 1'b1;
            next_done = 1'b1;
            next_state = S_IDLE;
          end else if ((dev_rdata & step.data) != 16'h0000) begin
            next_idx = 5'(idx + 1'b1);
          end
        end else begin
          next_pid = rd_pid;
          if (step.data[0]) begin
            next_count = dev_rdata[9:0];
          end
          if (rd_pid == PID_STALL || rd_pid == PID_ERR || rd_pid == PID_NAK) begin
            next_err = 1'b1;
          end
          next_idx = 5'(idx + 1'b1);
        end
      end
      S_TMR: begin
        if (step.kind == K_WAITSE0 && !se0_s) begin
          tif.start = 1'b1;
        end else if (tif.done) begin
          next_idx = 5'(idx + 1'b1);
          next_state = S_EXEC;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      idx <= 5'd0;
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      dev_addr <= 8'h00;
      dev_wdata <= 16'h0000;
      done <= 1'b0;
      err <= 1'b0;
      det <= 1'b0;
      pid <= 4'h0;
      count <= 10'h000;
      frame_cnt <= FRAME_FULL;
    end else begin
      state <= next_state;
      idx <= next_idx;
      dev_wr <= next_dev_wr;
      dev_rd <= next_dev_rd;
      dev_addr <= next_dev_addr;
      dev_wdata <= next_dev_wdata;
      done <= next_done;
      err <= next_err;
      det <= next_det;
      pid <= next_pid;
      count <= next_count;
      frame_cnt <= next_frame_cnt;
    end
  end

  // Helper counters read only by the checks below.
  logic [31:0] tok_gap;
  logic [31:0] pu_hold;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tok_gap <= 32'hFFFFFFFF;
      pu_hold <= 32'h00000000;
    end else begin
      if (dev_wr && dev_addr == DEV_TOK && dev_wdata == TOK_SETUP) begin
        tok_gap <= 32'h00000001;
      end else if (tok_gap != 32'hFFFFFFFF) begin
        tok_gap <= tok_gap + 32'h00000001;
      end
      pu_hold <= (dev_wr && dev_addr == DEV_OTGCON) ? 32'h00000001 : pu_hold + 32'h00000001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_wr(logic [7:0] a, logic [15:0] d);
    dev_wr && dev_addr == a && dev_wdata == d;
  endsequence

  a_strobes_apart: assert property (!(dev_wr && dev_rd)) else $error("Both strobes high.");
  a_setup_token: assert property (s_wr(DEV_BD_STAT, BD_SETUP) |=> s_wr(DEV_TOK, TOK_SETUP))
    else $error("SETUP token not after setup descriptor.");
  a_in_token: assert property (s_wr(DEV_BD_STAT, BD_DATA_IN) |=> s_wr(DEV_TOK, TOK_IN))
    else $error("IN token not after data descriptor.");
  a_status_token: assert property ((op == CMD_CTRL_IN) and s_wr(DEV_BD_STAT, BD_STATUS)
    |=> s_wr(DEV_TOK, TOK_OUT_EP0)) else $error("Status OUT token missing.");
  a_flag_cleared: assert property (state == S_RDD && step.kind == K_POLL && step.addr == DEV_IR
    && dev_rdata[IR_TRN_BIT] && !dev_rdata[IR_DETACH_BIT] |-> ##[1:8] s_wr(DEV_IR, TRN_MASK))
    else $error("Token complete flag not cleared by a one.");
  a_ctrl_ep0: assert property (op == CMD_CTRL_IN && dev_wr && dev_addr == DEV_EP0
    |-> dev_wdata[5:0] == EP0_CTRL_VAL[5:0]) else $error("Control endpoint value wrong.");
  a_bulk_count: assert property (op == CMD_BULK_OUT && dev_wr && dev_addr == DEV_BD_STAT
    |-> dev_wdata[9:0] <= BULK_MAX && dev_wdata[BD_OWN_BIT]) else $error("Bulk count over 64.");
  a_frame_gap: assert property (s_wr(DEV_TOK, TOK_SETUP) |-> tok_gap >= MS_CYCLES)
    else $error("Two control transactions in one frame.");
  a_pulse_width: assert property ((op == CMD_SRP) and s_wr(DEV_OTGCON, 16'h0000)
    |-> pu_hold >= DPULSE_MIN_MS * MS_CYCLES && pu_hold <= DPULSE_MAX_MS * MS_CYCLES)
    else $error("D+ pulse outside 5 to 10 ms.");
  a_target_range: assert property (dev_wr && dev_addr == DEV_ADDR |-> dev_wdata[15:7] == 9'h000)
    else $error("Target address wider than seven bits.");
  a_low_speed: assert property (dev_wr && dev_addr == DEV_EP0
    |-> dev_wdata[EP0_LOW_SPEED_SELECT_BIT] == cfg_ls && dev_wdata[EP0_NORETRY_BIT] == cfg_noretry)
    else $error("Speed or retry bit wrong.");
endmodule // usbh_ctl

/* File: hw/usbh_pkg.sv */
/*
  Constants and types shared by the USB host sequencer and its millisecond timer.
  Assumes a 25 MHz mclk and the USB module's register port as laid out below.
*/
package usbh_pkg;
  localparam int unsigned MCLK_HZ = 25_000_000;
  localparam int unsigned FRAME_MS = 1;
  localparam int unsigned MS_CYCLES = MCLK_HZ / 1000 * FRAME_MS;
  localparam logic [3:0] SE0_IDLE_MS = 4'h2;
  localparam logic [3:0] DPULSE_MS = 4'h7;
  localparam int unsigned DPULSE_MIN_MS = 5;
  localparam int unsigned DPULSE_MAX_MS = 10;

  localparam logic [7:0] DEV_EP0 = 8'h00;
  localparam logic [7:0] DEV_ADDR = 8'h01;
  localparam logic [7:0] DEV_TOK = 8'h02;
  localparam logic [7:0] DEV_IR = 8'h03;
  localparam logic [7:0] DEV_OTGIR = 8'h04;
  localparam logic [7:0] DEV_OTGCON = 8'h05;
  localparam logic [7:0] DEV_CFG2 = 8'h06;
  localparam logic [7:0] DEV_BD_ADR = 8'h10;
  localparam logic [7:0] DEV_BD_STAT = 8'h11;

  localparam logic [15:0] EP0_CTRL_VAL = 16'h000D;
  localparam logic [15:0] EP0_BULK_VAL = 16'h001D;
  localparam int unsigned EP0_LOW_SPEED_SELECT_BIT = 7;
  localparam int unsigned EP0_NORETRY_BIT = 6;
  localparam logic [15:0] BD_SETUP = 16'h8008;
  localparam logic [15:0] BD_DATA_IN = 16'hC040;
  localparam logic [15:0] BD_STATUS = 16'h8000;
  localparam int unsigned BD_OWN_BIT = 15;
  localparam int unsigned BD_DTS_BIT = 14;
  localparam int unsigned BD_PID_LSB = 2;
  localparam logic [15:0] SETUP_LEN = 16'h0008;
  localparam logic [9:0] BULK_MAX = 10'h040;
  localparam logic [15:0] TOK_SETUP = 16'h00D0;
  localparam logic [15:0] TOK_IN = 16'h0090;
  localparam logic [15:0] TOK_OUT_EP0 = 16'h0001;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;
  localparam logic [3:0] PID_ERR = 4'hF;
  localparam int unsigned IR_DETACH_BIT = 0;
  localparam int unsigned IR_TRN_BIT = 3;
  localparam int unsigned OTGIR_SESEND_BIT = 2;
  localparam int unsigned OTGIR_SESVD_BIT = 3;
  localparam int unsigned OTGCON_VBUS_DISCHARGE_ENABLE_BIT = 0;
  localparam int unsigned OTGCON_DPPU_BIT = 7;
  localparam int unsigned CFG2_VBUS_PULSE_ENABLE_BIT = 4;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h01;
  localparam logic [7:0] REG_CFG = 8'h02;
  localparam logic [7:0] REG_BUF = 8'h03;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_EP = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_COUNT = 8'h07;
  localparam logic [1:0] CMD_CTRL_IN = 2'h1;
  localparam logic [1:0] CMD_BULK_OUT = 2'h2;
  localparam logic [1:0] CMD_SRP = 2'h3;

  typedef enum logic [2:0] {
    K_WR = 3'b000,
    K_POLL = 3'b001,
    K_RD = 3'b010,
    K_WAITF = 3'b011,
    K_WAITSE0 = 3'b100,
    K_WAITMS = 3'b101,
    K_DONE = 3'b110
  } usbh_kind_e;

  typedef struct packed {
    usbh_kind_e kind;
    logic [7:0] addr;
    logic [15:0] data;
    logic [3:0] ms;
  } usbh_step_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EXEC = 3'b001,
    S_RDS = 3'b010,
    S_RDD = 3'b011,
    S_TMR = 3'b100
  } usbh_state_e;
endpackage

/* File: hw/usbh_tmr.sv */
/*
  Millisecond timer: a start pulse loads a count of milliseconds, done is high when idle.
  Assumes mclk runs at the rate that MS_CYCLES was derived from.
*/
`timescale 1ns/1ps
module usbh_tmr #(
  parameter int unsigned MS_CYCLES = usbh_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  usbh_tmr_if.tmr tif
);
  import usbh_pkg::*;
  localparam int unsigned PW = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("MS_CYCLES must be at least 2.");
  end

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic running;
  logic next_running;
  logic tick;

  assign tick = running && (pre == PRE_LAST);
  assign tif.done = !running;

  always_comb begin
    next_pre = running ? (tick ? '0 : PW'(pre + 1'b1)) : '0;
    next_cnt = cnt;
    next_running = running;
    if (tif.start) begin
      next_pre = '0;
      next_cnt = tif.ms;
      next_running = 1'b1;
    end else if (tick) begin
      next_cnt = 4'(cnt - 1'b1);
      next_running = (cnt != 4'h1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre <= '0;
      cnt <= 4'h0;
      running <= 1'b0;
    end else begin
      pre <= next_pre;
      cnt <= next_cnt;
      running <= next_running;
    end
  end
endmodule // usbh_tmr

/* File: hw/usbh_tmr_if.sv */
/*
  Start and done handshake between the sequencer and its millisecond timer.
  Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
interface usbh_tmr_if;
  logic start;
  logic [3:0] ms;
  logic done;
  modport ctl (output start, output ms, input done);
  modport tmr (input start, input ms, output done);
endinterface
